// ===== core/ahts_pkg.sv
`default_nettype none
package ahts_pkg;
    // register byte addresses on the wishbone slave
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] CHSEL_ADDR = 4'h4;
    localparam logic [3:0] RESULT_ADDR = 4'h8;
    localparam logic [3:0] STATUS_ADDR = 4'hC;
    // control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_WAIT_BIT = 2;
    localparam int CTRL_SCAN_BIT = 3;
    localparam int CTRL_SEQ_BIT = 4;
    // channel select layout: four 4-bit slots, slot 0 lowest
    localparam int CH_W = 4;
    localparam int SLOTS = 4;
    localparam logic [1:0] LAST_SLOT = 2'h3;
    localparam logic [1:0] FIRST_SLOT = 2'h0;
    localparam int RES_W = 10;
    // time taken by one conversion of the converter core
    localparam int CONV_NS = 2000;
    localparam int CLK_NS = 40;
    localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [6:0] CONV_LAST = 7'(CONV_CYC - 1);
    // stabilization time software must observe before starting
    localparam int STAB_NS = 1000;
    localparam logic [15:0] CHSEL_RESET = 16'h3210;
    typedef enum logic [1:0] {ST_STOP, ST_STANDBY, ST_TRIGWAIT, ST_CONVERT} ahts_state_t;
endpackage
`default_nettype wire

// ===== core/ahts_seq.sv
// Contract
// - No-wait: enabling from stop enters conversion standby, no conversion starts.
// - No-wait: start only arms; a trigger with start set begins conversion.
// - Select mode converts the single channel named by slot 0.
// - Scan mode converts slots 0 to 3 in order after a trigger.
// - Each finished conversion stores the result and pulses the done interrupt.
// - No-wait scan one-shot: keep start set, return to trigger standby after pass.
// - Trigger during conversion aborts and restarts at the first channel.
// - Any channel select write during conversion aborts and restarts first channel.
// - Writing start 1 during conversion aborts and restarts at first channel.
// - No-wait: clearing start mid-conversion aborts into powered standby.
// - No-wait: clearing enable in standby stops; triggers ignored with start 0.
// - Wait mode: enabling from stop goes straight to trigger standby.
// - Wait mode: trigger in standby starts conversion and sets start.
// - Select sequential: each conversion is followed at once by another.
// - Scan sequential: after four channels the next pass begins automatically.
// - Wait one-shot: after finishing, hardware clears start and stops converter.
// - Wait mode: clearing start mid-conversion aborts, standby, converter powered down.
// - Wait mode: with enable 0 triggers are ignored, nothing converts.
`default_nettype none
module ahts_seq
    import ahts_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic hwTrigger,
    input wire logic [RES_W-1:0] coreResult,
    output logic [CH_W-1:0] sampleChannel,
    output logic coreSampling,
    output logic corePowered,
    output logic conversion_done_irq
);
    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    logic converter_power_enable;
    logic conversion_start_bit;
    logic waitMode;
    logic scanMode;
    logic seqMode;
    logic [15:0] channel_select_reg;
    logic [RES_W-1:0] conversion_result_reg;
    ahts_state_t state;
    logic [1:0] slot;
    logic [6:0] convCount;
    logic busWrite;
    logic ctrlWrite;
    logic chselWrite;
    logic startSetWrite;
    logic startClrWrite;
    logic enClrWrite;
    logic trigTaken;
    logic convEnd;
    logic passEnd;
    logic restart;

    assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign ctrlWrite = busWrite && (wb_adr_i[3:0] == CTRL_ADDR);
    assign chselWrite = busWrite && (wb_adr_i[3:0] == CHSEL_ADDR);
    assign startSetWrite = ctrlWrite && wb_dat_i[CTRL_START_BIT] && wb_dat_i[CTRL_EN_BIT];
    assign startClrWrite = ctrlWrite && !wb_dat_i[CTRL_START_BIT];
    assign enClrWrite = ctrlWrite && !wb_dat_i[CTRL_EN_BIT];

    // ack one cycle after request, dropped the next cycle
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end

    // read data, unmapped addresses read zero
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            wb_dat_o <= 32'h0;
        else
        begin
            case (wb_adr_i[3:0])
                CTRL_ADDR: wb_dat_o <= {27'h0, seqMode, scanMode, waitMode,
                    conversion_start_bit, converter_power_enable};
                CHSEL_ADDR: wb_dat_o <= {16'h0, channel_select_reg};
                RESULT_ADDR: wb_dat_o <= {22'h0, conversion_result_reg};
                STATUS_ADDR: wb_dat_o <= {28'h0, slot, 2'(state)};
                default: wb_dat_o <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration and control bits
    // mode bits are only taken while not converting
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            waitMode <= 1'b0;
            scanMode <= 1'b0;
            seqMode <= 1'b0;
        end
        else if (ctrlWrite && state != ST_CONVERT)
        begin
            waitMode <= wb_dat_i[CTRL_WAIT_BIT];
            scanMode <= wb_dat_i[CTRL_SCAN_BIT];
            seqMode <= wb_dat_i[CTRL_SEQ_BIT];
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            converter_power_enable <= 1'b0;
        else if (ctrlWrite)
            converter_power_enable <= wb_dat_i[CTRL_EN_BIT];
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            channel_select_reg <= CHSEL_RESET;
        else if (chselWrite)
            channel_select_reg <= wb_dat_i[15:0];
    end

    // start bit: software writes, hardware sets in wait mode, clears on wait one-shot end
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            conversion_start_bit <= 1'b0;
        else if (trigTaken && waitMode)
            conversion_start_bit <= 1'b1;
        else if (ctrlWrite)
            conversion_start_bit <= wb_dat_i[CTRL_START_BIT] && wb_dat_i[CTRL_EN_BIT];
        else if (passEnd && waitMode && !seqMode)
            conversion_start_bit <= 1'b0;
        else if (!converter_power_enable)
            conversion_start_bit <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    // trigger accepted only when armed; ignored when enable is 0, or when start is 0 outside wait mode
    assign trigTaken = hwTrigger && converter_power_enable && !ctrlWrite
        && (state == ST_CONVERT || (state == ST_TRIGWAIT
        && (waitMode || conversion_start_bit)));
    assign convEnd = state == ST_CONVERT && convCount == CONV_LAST && !restart;
    assign passEnd = convEnd && (!scanMode || slot == LAST_SLOT);
    // any of these aborts the running conversion and restarts at slot 0
    assign restart = state == ST_CONVERT && (trigTaken || chselWrite
        || startSetWrite);

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            state <= ST_STOP;
        else
        begin
            case (state)
                ST_STOP:
                    if (ctrlWrite && wb_dat_i[CTRL_EN_BIT])
                        state <= wb_dat_i[CTRL_WAIT_BIT] ? ST_TRIGWAIT : ST_STANDBY;
                ST_STANDBY:
                    if (enClrWrite)
                        state <= ST_STOP;
                    else if (startSetWrite)
                        state <= ST_TRIGWAIT;
                ST_TRIGWAIT:
                    if (enClrWrite)
                        state <= ST_STOP;
                    else if (!waitMode && startClrWrite)
                        state <= ST_STANDBY;
                    else if (trigTaken)
                        state <= ST_CONVERT;
                ST_CONVERT:
                    if (enClrWrite)
                        state <= ST_STOP;
                    else if (startClrWrite)
                        state <= waitMode ? ST_TRIGWAIT : ST_STANDBY;
                    else if (restart)
                        state <= ST_CONVERT;
                    else if (passEnd && !seqMode)
                        state <= waitMode ? ST_STOP : ST_TRIGWAIT;
                default: state <= ST_STOP;
            endcase
        end
    end

    // slot and per-conversion timer
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            slot <= FIRST_SLOT;
            convCount <= 7'h0;
        end
        else if (state != ST_CONVERT || restart)
        begin
            slot <= FIRST_SLOT;
            convCount <= 7'h0;
        end
        else if (convEnd)
        begin
            convCount <= 7'h0;
            slot <= (scanMode && slot != LAST_SLOT) ? slot + 2'h1 : FIRST_SLOT;
        end
        else
            convCount <= convCount + 7'h1;
    end

    // result and done pulse; aborted conversions store nothing
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            conversion_result_reg <= '0;
            conversion_done_irq <= 1'b0;
        end
        else
        begin
            conversion_done_irq <= convEnd && !startClrWrite && !enClrWrite;
            if (convEnd && !startClrWrite && !enClrWrite)
                conversion_result_reg <= coreResult;
        end
    end

    // analog core drive
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sampleChannel <= 4'h0;
            coreSampling <= 1'b0;
            corePowered <= 1'b0;
        end
        else
        begin
            sampleChannel <= scanMode ? channel_select_reg[slot*CH_W +: CH_W]
                : channel_select_reg[CH_W-1:0];
            coreSampling <= state == ST_CONVERT;
            corePowered <= state == ST_STANDBY || state == ST_CONVERT
                || (state == ST_TRIGWAIT && !waitMode);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    sequence convRun_s;
        state == ST_CONVERT && !restart && !startClrWrite && !enClrWrite;
    endsequence

    // software or trigger abort of the running conversion
    sequence abortReq_s;
        state == ST_CONVERT && restart;
    endsequence

    // start cleared by software while converting, enable kept
    sequence startDrop_s;
        state == ST_CONVERT && startClrWrite && !enClrWrite;
    endsequence

    stop_to_standby_a: assert property (@(posedge clock) disable iff (sys_rst)
        state == ST_STOP && ctrlWrite && wb_dat_i[CTRL_EN_BIT] && !wb_dat_i[CTRL_WAIT_BIT]
        |=> state == ST_STANDBY && !coreSampling[*2])
        else $error("enable from stop did not reach standby");
    arm_no_conv_a: assert property (@(posedge clock) disable iff (sys_rst)
        state == ST_STANDBY && startSetWrite |=> state == ST_TRIGWAIT)
        else $error("start did not only arm");
    trig_ignored_a: assert property (@(posedge clock) disable iff (sys_rst)
        state != ST_CONVERT && !waitMode && !conversion_start_bit |=> state != ST_CONVERT)
        else $error("trigger taken with start clear");
    done_pulse_a: assert property (@(posedge clock) disable iff (sys_rst)
        convRun_s and convCount == CONV_LAST |=> conversion_done_irq
        && conversion_result_reg == $past(coreResult))
        else $error("result not stored at conversion end");
    restart_slot_a: assert property (@(posedge clock) disable iff (sys_rst)
        restart |=> slot == FIRST_SLOT && convCount == 7'h0)
        else $error("abort did not restart at first channel");
    wait_trig_a: assert property (@(posedge clock) disable iff (sys_rst)
        state == ST_TRIGWAIT && waitMode && trigTaken |=> conversion_start_bit
        && state == ST_CONVERT)
        else $error("wait trigger did not set start");
    oneshot_stop_a: assert property (@(posedge clock) disable iff (sys_rst)
        convRun_s and passEnd && waitMode && !seqMode && !ctrlWrite
        |=> state == ST_STOP && !conversion_start_bit)
        else $error("wait one-shot did not stop");
    nowait_pass_a: assert property (@(posedge clock) disable iff (sys_rst)
        convRun_s and passEnd && !waitMode && !seqMode && !ctrlWrite
        |=> state == ST_TRIGWAIT && conversion_start_bit)
        else $error("no-wait one-shot did not re-arm");
    seq_cont_a: assert property (@(posedge clock) disable iff (sys_rst)
        convRun_s and convEnd && seqMode |=> state == ST_CONVERT ##1 coreSampling)
        else $error("sequential mode did not continue");
    wait_abort_a: assert property (@(posedge clock) disable iff (sys_rst)
        state == ST_CONVERT && waitMode && startClrWrite && !enClrWrite
        |=> state == ST_TRIGWAIT ##1 !corePowered)
        else $error("wait abort left converter powered");

    // channel routing and scan order
    select_chan_a: assert property (@(posedge clock) disable iff (sys_rst)
        state == ST_CONVERT && !scanMode
        |=> sampleChannel == $past(channel_select_reg[CH_W-1:0]))
        else $error("select mode drove the wrong channel");
    scan_chan_a: assert property (@(posedge clock) disable iff (sys_rst)
        state == ST_CONVERT && scanMode
        |=> sampleChannel == $past(channel_select_reg[slot*CH_W +: CH_W]))
        else $error("scan mode drove the wrong channel");
    scan_order_a: assert property (@(posedge clock) disable iff (sys_rst)
        convEnd && scanMode && slot != LAST_SLOT
        |=> slot == $past(slot) + 2'h1)
        else $error("scan slots not taken in order");
    scan_wrap_a: assert property (@(posedge clock) disable iff (sys_rst)
        convRun_s and passEnd && scanMode && seqMode
        |=> state == ST_CONVERT && slot == FIRST_SLOT)
        else $error("sequential scan did not start the next pass");

    // aborts, enable and timer bounds
    nowait_abort_a: assert property (@(posedge clock) disable iff (sys_rst)
        startDrop_s and !waitMode |=> state == ST_STANDBY ##1 corePowered)
        else $error("no-wait abort powered the converter down");
    abort_quiet_a: assert property (@(posedge clock) disable iff (sys_rst)
        abortReq_s |=> state == ST_CONVERT && !conversion_done_irq)
        else $error("aborted conversion was reported");
    wait_enable_a: assert property (@(posedge clock) disable iff (sys_rst)
        state == ST_STOP && ctrlWrite && wb_dat_i[CTRL_EN_BIT] && wb_dat_i[CTRL_WAIT_BIT]
        |=> state == ST_TRIGWAIT && !corePowered)
        else $error("wait enable did not reach trigger standby");
    disabled_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
        !converter_power_enable |=> !coreSampling)
        else $error("conversion ran with enable clear");
    count_bound_a: assert property (@(posedge clock) disable iff (sys_rst)
        convCount <= CONV_LAST)
        else $error("conversion timer ran past its end");
endmodule
`default_nettype wire

// ===== bench/ahts_tb.sv
`default_nettype none
module tb
    import ahts_pkg::*;
;
timeunit 1ns;
timeprecision 1ps;
logic clock = 1'b0;
logic sys_rst = 1'b1;
logic [31:0] wbAdr = 32'h0;
logic [31:0] wbDatI = 32'h0;
logic [31:0] wbDatO;
logic wbWe = 1'b0;
logic [3:0] wbSel = 4'h0;
logic wbCyc = 1'b0;
logic wbStb = 1'b0;
logic wbAck;
logic hwTrigger = 1'b0;
logic [RES_W-1:0] coreResult = 10'h0;
logic [CH_W-1:0] sampleChannel;
logic coreSampling;
logic corePowered;
logic doneIrq;
logic [CH_W-1:0] lastCh = 4'h0;
int error_cnt = 0;
int checks_done = 0;
////////////////////////////////////////////////////////////////////////////////
ahts_seq uut (.clock(clock), .sys_rst(sys_rst), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_we_i(wbWe), .wb_sel_i(wbSel), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_ack_o(wbAck), .hwTrigger(hwTrigger), .coreResult(coreResult),
    .sampleChannel(sampleChannel), .coreSampling(coreSampling), .corePowered(corePowered),
    .conversion_done_irq(doneIrq));
// clock at 40 ns period
always #20 clock = ~clock;
// core result tagged with the channel being converted
always @(posedge clock) coreResult <= {6'h2D, sampleChannel};
// channel of the previous cycle, read when the done pulse shows
always @(negedge clock) lastCh <= sampleChannel;
////////////////////////////////////////////////////////////////////////////////
task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask
// value comparison
task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
        error_cnt++;
        $display("wrong value %s expected %h seen %h", name, exp, got);
    end
endtask
// classic wishbone cycle, held until ack is seen
task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat,
    output logic [31:0] rd);
    int n;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {28'h0, adr};
    wbDatI <= dat;
    wbSel <= 4'hF;
    n = 0;
    do
    begin
        @(posedge clock);
        n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (n >= 50)
    begin
        chk("bus ack", 32'h1, 32'h0);
        complete_run();
    end
    // read data taken at the rising edge where ack is seen, then release
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
endtask
task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wb(1'b1, adr, dat, d);
endtask
task automatic rdm(input string name, input logic [3:0] adr, input logic [31:0] mask,
    input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, adr, 32'h0, d);
    chk(name, exp, d & mask);
endtask
// one-cycle trigger pulse
task automatic trig();
    @(posedge clock);
    hwTrigger <= 1'b1;
    @(posedge clock);
    hwTrigger <= 1'b0;
endtask
// wait for a done pulse, then check channel and stored result
task automatic done_on(input logic [3:0] ch);
    int n;
    logic [3:0] c;
    n = 0;
    do
    begin
        @(negedge clock);
        n++;
    end while (doneIrq !== 1'b1 && n < 200);
    if (n >= 200)
    begin
        chk("done pulse", 32'h1, 32'h0);
        complete_run();
    end
    c = lastCh;
    chk("channel", {28'h0, ch}, {28'h0, c});
    rdm("result", RESULT_ADDR, 32'h3FF, {22'h0, 6'h2D, ch});
endtask
// no done pulse for n cycles
task automatic quiet(input int n);
    repeat (n)
    begin
        @(negedge clock);
        chk("no done", 32'h0, {31'h0, doneIrq});
    end
endtask
task automatic mid();
    repeat (20) @(posedge clock);
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    rdm("chsel reset", CHSEL_ADDR, 32'hFFFF, 32'h3210);
    rdm("state reset", STATUS_ADDR, 32'h3, 32'h0);
    // no-wait select one-shot
    wr(CHSEL_ADDR, 32'h7531);
    wr(CTRL_ADDR, 32'h01);
    rdm("state", STATUS_ADDR, 32'h3, 32'h1);
    quiet(STAB_NS / CLK_NS);
    wr(CTRL_ADDR, 32'h03);
    rdm("state", STATUS_ADDR, 32'h3, 32'h2);
    quiet(60);
    trig();
    done_on(4'h1);
    rdm("start", CTRL_ADDR, 32'h2, 32'h2);
    $display("test no-wait select done");
    // no-wait scan one-shot, with aborts
    wr(CTRL_ADDR, 32'h0B);
    trig();
    done_on(4'h1);
    done_on(4'h3);
    done_on(4'h5);
    done_on(4'h7);
    quiet(60);
    rdm("start", CTRL_ADDR, 32'h2, 32'h2);
    trig();
    done_on(4'h1);
    mid();
    trig();
    done_on(4'h1);
    mid();
    wr(CHSEL_ADDR, 32'h7536);
    done_on(4'h6);
    mid();
    wr(CHSEL_ADDR, 32'h7536);
    done_on(4'h6);
    mid();
    wr(CTRL_ADDR, 32'h0B);
    done_on(4'h6);
    mid();
    wr(CTRL_ADDR, 32'h09);
    quiet(100);
    chk("powered", 32'h1, {31'h0, corePowered});
    rdm("state", STATUS_ADDR, 32'h3, 32'h1);
    trig();
    quiet(100);
    wr(CTRL_ADDR, 32'h00);
    rdm("state", STATUS_ADDR, 32'h3, 32'h0);
    $display("test no-wait scan done");
    // wait select sequential
    wr(CHSEL_ADDR, 32'h0009);
    wr(CTRL_ADDR, 32'h15);
    rdm("state", STATUS_ADDR, 32'h3, 32'h2);
    trig();
    done_on(4'h9);
    done_on(4'h9);
    rdm("start", CTRL_ADDR, 32'h2, 32'h2);
    mid();
    wr(CTRL_ADDR, 32'h15);
    quiet(100);
    chk("powered", 32'h0, {31'h0, corePowered});
    rdm("state", STATUS_ADDR, 32'h3, 32'h2);
    wr(CTRL_ADDR, 32'h14);
    trig();
    quiet(100);
    chk("sampling", 32'h0, {31'h0, coreSampling});
    $display("test wait select done");
    // wait scan one-shot, then sequential
    wr(CHSEL_ADDR, 32'h7531);
    wr(CTRL_ADDR, 32'h0D);
    trig();
    done_on(4'h1);
    done_on(4'h3);
    done_on(4'h5);
    done_on(4'h7);
    quiet(60);
    rdm("start", CTRL_ADDR, 32'h2, 32'h0);
    chk("powered", 32'h0, {31'h0, corePowered});
    wr(CTRL_ADDR, 32'h00);
    wr(CTRL_ADDR, 32'h1D);
    trig();
    done_on(4'h1);
    done_on(4'h3);
    done_on(4'h5);
    done_on(4'h7);
    done_on(4'h1);
    $display("test wait scan done");
    complete_run();
end
endmodule
`default_nettype wire
